// ==== rtl/ogb_cfg.svh ====
`ifndef OGB_CFG_SVH
`define OGB_CFG_SVH

`define OGB_WORD_W 8
`define OGB_LEN_W 4
`define OGB_LANES 2
`define OGB_LEN_SER7 4'h7
`define OGB_LEN_DDR8 4'h8
`define OGB_LEN_HALF 4'h4
`define OGB_LEN_NONE 4'h0
`define OGB_HALF_LO 0
`define OGB_HALF_HI 4
`define OGB_WORD_RST 8'h00

`endif

// ==== rtl/ogb_pkg.sv ====
package ogb_pkg;

	typedef enum logic [1:0] {
		SER_SEVEN_MODE = 2'b00,
		DDR_EIGHT_TO_ONE_MODE = 2'b01,
		DDR_FOUR_TO_ONE_MODE = 2'b10
	} ogb_mode_t;

endpackage : ogb_pkg

// ==== rtl/ogb_shift_lane.sv ====
`timescale 1ns/1ps
`include "ogb_cfg.svh"

module ogb_shift_lane (
	input wire logic clk_sys, // fast edge clock of the block
	input wire logic rstN, // synchronised reset, active low
	input wire logic loadEn, // one-cycle load of a new word
	input wire logic [`OGB_WORD_W-1:0] loadWord, // word to serialise, bit 0 first
	input wire logic [`OGB_LEN_W-1:0] loadLen, // bits in the word, 0 leaves lane idle
	output logic serBit // serial bit, straight from a flop
);

	logic [`OGB_WORD_W-1:0] shift_reg, shift_next;
	logic [`OGB_LEN_W-1:0] remain_reg, remain_next;
	logic ser_reg, ser_next;

	always_comb begin
		shift_next = shift_reg;
		remain_next = remain_reg;
		ser_next = 1'b0;
		if (loadEn && (loadLen != `OGB_LEN_NONE)) begin
			ser_next = loadWord[0];
			shift_next = loadWord >> 1;
			remain_next = loadLen - 4'h1;
		end else if (remain_reg != `OGB_LEN_NONE) begin
			ser_next = shift_reg[0];
			shift_next = shift_reg >> 1;
			remain_next = remain_reg - 4'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			shift_reg <= `OGB_WORD_RST;
			remain_reg <= `OGB_LEN_NONE;
			ser_reg <= 1'b0;
		end else begin
			shift_reg <= shift_next;
			remain_reg <= remain_next;
			ser_reg <= ser_next;
		end
	end

	assign serBit = ser_reg;

endmodule : ogb_shift_lane

// ==== rtl/output_serializer_gearbox.sv ====
`timescale 1ns/1ps
`include "ogb_cfg.svh"

module output_serializer_gearbox (
	input wire logic clk_sys, // fast edge clock, 250 MHz
	input wire logic nrst, // asynchronous reset, active low
	input wire logic slowClk, // slow system clock from the core
	input wire logic [`OGB_WORD_W-1:0] dataIn, // parallel word from the core
	input wire logic [1:0] modeSel, // gearbox mode, ogb_mode_t code
	output logic serOutA, // serial out, first_half_cell / whole gearbox
	output logic serOutB // serial out, second_half_cell in split mode
);

	logic rstSync1, rstN;
	logic slowSync1, slowSync2, slowPrev_reg;
	logic [`OGB_WORD_W-1:0] dataSync1, dataSync2;
	logic [1:0] modeSync1, modeSync2;
	logic [`OGB_WORD_W-1:0] capture_reg, capture_next;
	ogb_pkg::ogb_mode_t mode_reg, mode_next;
	logic loadPend_reg, loadPend_next;
	logic slowFall;
	logic [`OGB_WORD_W-1:0] laneWord [`OGB_LANES];
	logic [`OGB_LEN_W-1:0] laneLen [`OGB_LANES];
	logic [`OGB_LANES-1:0] laneBit;

	// reset takes hold at once but lets go only after two clean edges
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rstSync1 <= 1'b0;
			rstN <= 1'b0;
		end else begin
			rstSync1 <= 1'b1;
			rstN <= rstSync1;
		end
	end

	// everything from the core is treated as foreign and double flopped
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			slowSync1 <= 1'b0;
			slowSync2 <= 1'b0;
			slowPrev_reg <= 1'b0;
			dataSync1 <= `OGB_WORD_RST;
			dataSync2 <= `OGB_WORD_RST;
			modeSync1 <= 2'h0;
			modeSync2 <= 2'h0;
		end else begin
			slowSync1 <= slowClk;
			slowSync2 <= slowSync1;
			slowPrev_reg <= slowSync2;
			dataSync1 <= dataIn;
			dataSync2 <= dataSync1;
			modeSync1 <= modeSel;
			modeSync2 <= modeSync1;
		end
	end

	// sample mid-period, on the falling edge, where the word launched on the
	// rising edge has long settled through both synchroniser stages
	assign slowFall = slowPrev_reg & ~slowSync2;

	always_comb begin
		capture_next = capture_reg;
		mode_next = mode_reg;
		loadPend_next = slowFall;
		if (slowFall) begin
			capture_next = dataSync2;
			mode_next = ogb_pkg::ogb_mode_t'(modeSync2);
		end
	end

	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			capture_reg <= `OGB_WORD_RST;
			mode_reg <= ogb_pkg::SER_SEVEN_MODE;
			loadPend_reg <= 1'b0;
		end else begin
			capture_reg <= capture_next;
			mode_reg <= mode_next;
			loadPend_reg <= loadPend_next;
		end
	end

	// lane 0 is the whole gearbox or the low half, lane 1 only the high half
	// code 11 loads nothing, so both lanes stay low for that word
	always_comb begin
		laneWord[0] = capture_reg;
		laneLen[0] = `OGB_LEN_DDR8;
		laneWord[1] = `OGB_WORD_RST;
		laneLen[1] = `OGB_LEN_NONE;
		case (mode_reg)
			ogb_pkg::SER_SEVEN_MODE: begin
				laneWord[0] = {1'b0, capture_reg[6:0]};
				laneLen[0] = `OGB_LEN_SER7;
			end
			ogb_pkg::DDR_EIGHT_TO_ONE_MODE: begin
				laneWord[0] = capture_reg;
				laneLen[0] = `OGB_LEN_DDR8;
			end
			ogb_pkg::DDR_FOUR_TO_ONE_MODE: begin
				laneWord[0] = {4'h0, capture_reg[`OGB_HALF_LO+:4]};
				laneLen[0] = `OGB_LEN_HALF;
				laneWord[1] = {4'h0, capture_reg[`OGB_HALF_HI+:4]};
				laneLen[1] = `OGB_LEN_HALF;
			end
			default: begin
				laneWord[0] = capture_reg;
				laneLen[0] = `OGB_LEN_NONE;
			end
		endcase
	end

	genvar gi;
	generate
		for (gi = 0; gi < `OGB_LANES; gi++) begin : g_lane
			ogb_shift_lane u_lane (
				.clk_sys(clk_sys),
				.rstN(rstN),
				.loadEn(loadPend_reg),
				.loadWord(laneWord[gi]),
				.loadLen(laneLen[gi]),
				.serBit(laneBit[gi])
			);
		end
	endgenerate

	assign serOutA = laneBit[0];
	assign serOutB = laneBit[1];

	a_capture_on_fall: assert property (@(posedge clk_sys) disable iff (!rstN)
		slowFall |=> capture_reg == $past(dataSync2))
		else $error("word not captured on slow clock edge");

	a_mode_capture: assert property (@(posedge clk_sys) disable iff (!rstN)
		slowFall |=> mode_reg == $past(modeSync2))
		else $error("mode not captured with the word");

	a_handoff_next: assert property (@(posedge clk_sys) disable iff (!rstN)
		slowFall |=> loadPend_reg ##1 !loadPend_reg)
		else $error("hand-off pulse not one cycle after capture");

	a_first_bit_low: assert property (@(posedge clk_sys) disable iff (!rstN)
		loadPend_reg &&
		(mode_reg inside {ogb_pkg::SER_SEVEN_MODE, ogb_pkg::DDR_EIGHT_TO_ONE_MODE})
		|=> serOutA == $past(capture_reg[0]))
		else $error("first serial bit is not bit 0");

	a_eighth_bit: assert property (@(posedge clk_sys) disable iff (!rstN)
		loadPend_reg && (mode_reg == ogb_pkg::DDR_EIGHT_TO_ONE_MODE) ##1 (!loadPend_reg)[*7]
		|=> serOutA == $past(capture_reg[7], 8))
		else $error("eighth bit of 8:1 word wrong");

	a_seven_stop: assert property (@(posedge clk_sys) disable iff (!rstN)
		loadPend_reg && (mode_reg == ogb_pkg::SER_SEVEN_MODE) ##1 (!loadPend_reg)[*8]
		|-> serOutA == 1'b0)
		else $error("7:1 mode sent more than seven bits");

	a_split_high: assert property (@(posedge clk_sys) disable iff (!rstN)
		loadPend_reg && (mode_reg == ogb_pkg::DDR_FOUR_TO_ONE_MODE)
		|=> serOutB == $past(capture_reg[4]) && serOutA == $past(capture_reg[0]))
		else $error("split halves not on their own outputs");

	a_lane_b_quiet: assert property (@(posedge clk_sys) disable iff (!rstN)
		loadPend_reg && (mode_reg != ogb_pkg::DDR_FOUR_TO_ONE_MODE) ##1 (!loadPend_reg)[*4]
		|-> serOutB == 1'b0)
		else $error("second half output active outside split mode");

	// the word checks below rely on a slow period that covers a whole word;
	// a faster slow clock restarts the lanes and truncates words by design
	a_reset_low: assert property (@(posedge clk_sys)
		!rstN |-> (serOutA == 1'b0) && (serOutB == 1'b0))
		else $error("serial outputs not low in reset");

	a_pend_after_fall: assert property (@(posedge clk_sys) disable iff (!rstN)
		loadPend_reg |-> $past(slowFall))
		else $error("hand-off pulse without a captured word");

	a_capture_steady: assert property (@(posedge clk_sys) disable iff (!rstN)
		!slowFall |=> $stable(capture_reg) && $stable(mode_reg))
		else $error("captured word changed between slow clock edges");

	a_seventh_bit: assert property (@(posedge clk_sys) disable iff (!rstN)
		loadPend_reg && (mode_reg == ogb_pkg::SER_SEVEN_MODE) ##1 (!loadPend_reg)[*6]
		|=> serOutA == $past(capture_reg[6], 7))
		else $error("seventh bit of 7:1 word wrong");

	a_seven_second: assert property (@(posedge clk_sys) disable iff (!rstN)
		loadPend_reg && (mode_reg == ogb_pkg::SER_SEVEN_MODE) ##1 !loadPend_reg
		|=> serOutA == $past(capture_reg[1], 2))
		else $error("second bit of 7:1 word wrong");

	a_middle_bit: assert property (@(posedge clk_sys) disable iff (!rstN)
		loadPend_reg && (mode_reg == ogb_pkg::DDR_EIGHT_TO_ONE_MODE) ##1 (!loadPend_reg)[*4]
		|=> serOutA == $past(capture_reg[4], 5))
		else $error("bits of 8:1 word not shifted in order");

	a_eight_second: assert property (@(posedge clk_sys) disable iff (!rstN)
		loadPend_reg && (mode_reg == ogb_pkg::DDR_EIGHT_TO_ONE_MODE) ##1 !loadPend_reg
		|=> serOutA == $past(capture_reg[1], 2))
		else $error("second bit of 8:1 word wrong");

	a_eight_stop: assert property (@(posedge clk_sys) disable iff (!rstN)
		loadPend_reg && (mode_reg == ogb_pkg::DDR_EIGHT_TO_ONE_MODE) ##1 (!loadPend_reg)[*8]
		|=> serOutA == 1'b0)
		else $error("8:1 mode sent more than eight bits");

	a_split_second: assert property (@(posedge clk_sys) disable iff (!rstN)
		loadPend_reg && (mode_reg == ogb_pkg::DDR_FOUR_TO_ONE_MODE) ##1 !loadPend_reg
		|=> serOutA == $past(capture_reg[1], 2) && serOutB == $past(capture_reg[5], 2))
		else $error("second bits of split halves wrong");

	a_split_last: assert property (@(posedge clk_sys) disable iff (!rstN)
		loadPend_reg && (mode_reg == ogb_pkg::DDR_FOUR_TO_ONE_MODE) ##1 (!loadPend_reg)[*3]
		|=> serOutA == $past(capture_reg[3], 4) && serOutB == $past(capture_reg[7], 4))
		else $error("last bits of split halves wrong");

	a_split_stop: assert property (@(posedge clk_sys) disable iff (!rstN)
		loadPend_reg && (mode_reg == ogb_pkg::DDR_FOUR_TO_ONE_MODE) ##1 (!loadPend_reg)[*4]
		|=> serOutA == 1'b0 && serOutB == 1'b0)
		else $error("split mode sent more than four bits per half");

	a_mode_none_quiet: assert property (@(posedge clk_sys) disable iff (!rstN)
		loadPend_reg && (2'(mode_reg) == 2'h3) |=> (serOutA == 1'b0 && serOutB == 1'b0)[*8])
		else $error("idle mode code sent serial bits");

endmodule : output_serializer_gearbox

// ==== test/ogb_core_model.sv ====
`timescale 1ns/1ps

module ogb_core_model (
	input wire logic clk_sys, // fast clock
	input wire logic nrst, // reset, active low
	input wire logic [7:0] nxtWord, // word for the next slow period
	input wire logic [1:0] nxtMode, // mode for the next slow period
	output logic slowClk, // slow clock, low in reset
	output logic [7:0] dataIn, // parallel word
	output logic [1:0] modeSel // mode code
);
	logic [4:0] cntReg;
	assign slowClk = cntReg[4];
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cntReg <= 5'h00;
			dataIn <= 8'h00;
			modeSel <= 2'h3;
		end else begin
			cntReg <= cntReg + 5'h01;
			// change only on the rise, so the word is steady across the fall
			if (cntReg == 5'h0f) begin
				dataIn <= nxtWord;
				modeSel <= nxtMode;
			end
		end
	end
endmodule : ogb_core_model

// ==== test/output_serializer_gearbox_tb.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
$display("unexpected at %0t: %h vs %h", $time, a, e); end end

module output_serializer_gearbox_tb;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic slowClk;
	logic [7:0] dataIn;
	logic [1:0] modeSel;
	logic serOutA;
	logic serOutB;
	logic [7:0] nW = 8'h00;
	logic [1:0] nM = 2'h3;
	logic [7:0] cW;
	logic [1:0] cM;
	logic [15:0] capA;
	logic [15:0] capB;
	int fail_count = 0;
	int compares = 0;
	int seed;
	initial forever #2 clk_sys = ~clk_sys;
	ogb_core_model core (.clk_sys(clk_sys), .nrst(nrst), .nxtWord(nW), .nxtMode(nM),
		.slowClk(slowClk), .dataIn(dataIn), .modeSel(modeSel));
	output_serializer_gearbox dut (.clk_sys(clk_sys), .nrst(nrst), .slowClk(slowClk),
		.dataIn(dataIn), .modeSel(modeSel), .serOutA(serOutA), .serOutB(serOutB));
	function automatic logic [7:0] laneBits(logic [7:0] w, logic [1:0] m, logic hi);
		case (m)
			2'h0: laneBits = hi ? 8'h00 : {1'b0, w[6:0]};
			2'h1: laneBits = hi ? 8'h00 : w;
			2'h2: laneBits = hi ? {4'h0, w[7:4]} : {4'h0, w[3:0]};
			default: laneBits = 8'h00;
		endcase
	endfunction : laneBits
	// edges from the first capture after the slow fall seen by the bench to the first serial bit
	localparam int LAT = 3;
	function automatic logic [15:0] frame(logic [7:0] b);
		frame = {8'h00, b} << LAT;
	endfunction : frame
	task automatic report_and_stop();
		$display("mismatches %0d, compares %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop
	task automatic holdReset();
		nrst <= 1'b0;
		@(posedge clk_sys);
		#1;
		`CHK({serOutA, serOutB}, 2'b00)
		repeat (7) @(posedge clk_sys);
		`CHK({serOutA, serOutB}, 2'b00)
		nrst <= 1'b1;
	endtask : holdReset
	// slowClk is looked at 1 ns after the edge, once the core model has moved it
	task automatic waitFall();
		while (slowClk !== 1'b1) begin
			@(posedge clk_sys);
			#1;
		end
		while (slowClk !== 1'b0) begin
			@(posedge clk_sys);
			#1;
		end
	endtask : waitFall
	task automatic checkWord(input int i);
		cW = nW;
		cM = nM;
		for (int k = 0; k < 16; k++) begin
			@(posedge clk_sys);
			if (k == 0) begin
				nW <= (i < 4) ? 8'hff : (i < 8) ? 8'h81 : 8'($urandom);
				nM <= 2'(i);
			end
			#1;
			capA[k] = serOutA;
			capB[k] = serOutB;
		end
		`CHK(capA, frame(laneBits(cW, cM, 1'b0)))
		`CHK(capB, frame(laneBits(cW, cM, 1'b1)))
	endtask : checkWord
	initial begin
		seed = $urandom(32'h0a6e);
		holdReset();
		for (int i = 0; i < 14; i++) begin
			waitFall();
			checkWord(i);
		end
		// reset lands while a word is still shifting out, then the link must recover
		waitFall();
		repeat (7) @(posedge clk_sys);
		holdReset();
		waitFall();
		checkWord(14);
		report_and_stop();
	end
	initial begin
		repeat (3000) @(posedge clk_sys);
		fail_count++;
		report_and_stop();
	end
endmodule : output_serializer_gearbox_tb
